// file: verilog/pgsc_pkg.sv
package pgsc_pkg;
    // Pin function selected by the active configuration
    typedef enum logic [1:0] {
        PGSC_FN_NONE    = 2'b00,
        PGSC_FN_SLEEP   = 2'b01,
        PGSC_FN_REBOOT  = 2'b10,
        PGSC_FN_INVALID = 2'b11
    } pgsc_fn_t;

    typedef enum logic [2:0] {
        PGSC_ST_HOLD   = 3'b000,
        PGSC_ST_LOAD   = 3'b001,
        PGSC_ST_RUN    = 3'b010,
        PGSC_ST_SLEEP  = 3'b011,
        PGSC_ST_WAKE   = 3'b100
    } pgsc_state_t;

    localparam int PGSC_SYNC_STAGES = 2;
    localparam int PGSC_CFG_SEL_W   = 2;
    localparam int PGSC_CFG_W       = 8;
    localparam int PGSC_LOAD_NS     = 1000;
    localparam int PGSC_MCLK_NS     = 100;
    localparam int PGSC_LOAD_CYC    = (PGSC_LOAD_NS + PGSC_MCLK_NS - 1) / PGSC_MCLK_NS;
    localparam int PGSC_LOAD_CNT_W  = 8;
    localparam logic [PGSC_CFG_W-1:0] PGSC_CFG_RST = 8'h00;
    // Factory code that allows the external serial memory fetch; value is arbitrary
    localparam logic [7:0] PGSC_EXT_FETCH_CODE = 8'h5a;
endpackage

// file: verilog/pgsc_sync.sv
`timescale 1ns/100ps
module pgsc_sync #(
    parameter int STAGES = 2
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic [STAGES-1:0] sync_q;
    logic [STAGES-1:0] sync_d;

    // Only the last stage is visible outside
    always_comb begin
        sync_d = {sync_q[STAGES-2:0], din};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q[STAGES-1];
endmodule

// file: verilog/pgsc_top.sv
// Contract
// R1: While the pin is low the start-up sequence waits; it resumes when high.
// R2: Controller holds the pin low from the start of power-up.
// R3: Controller raises the pin only after all rails are valid.
// R4: Controller keeps the pin low a hold time after the last output rail.
// R5: Sleep mode: first high loads a configuration chosen by select pins.
// R6: Sleep mode: later highs restore the earlier configuration, no fresh load.
// R7: Sleep mode: low level enters low power, synthesizer and logic off.
// R8: Leaving low power restores exactly the prior operating state.
// R9: Reboot mode: low level resets the device for a full rerun.
// R10: Reboot mode: high after a restart loads a configuration anew.
// R11: A configuration enables sleep or reboot variant, never both.
// R12: Without a pin function, clock outputs stay gated until last supply valid.
// R13: External memory fetch only when the factory code enables it.
// R14: The pin is synchronised before the state machine acts on it.
`timescale 1ns/100ps
module pgsc_top
    import pgsc_pkg::*;
#(
    parameter int                    LOAD_CYC   = PGSC_LOAD_CYC,
    parameter logic [7:0]            FACTORY_CODE = 8'h00
) (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      power_good_pin,
    input  wire logic [1:0]                pin_function,
    input  wire logic                      supplies_valid_level,
    input  wire logic [PGSC_CFG_SEL_W-1:0] cfg_select,
    input  wire logic [PGSC_CFG_W-1:0]     cfg_store_data,
    input  wire logic [PGSC_CFG_W-1:0]     cfg_ext_data,
    output logic                           startup_busy,
    output logic                           cfg_load_pulse,
    output logic                           ext_fetch_en,
    output logic                           synth_enable,
    output logic                           logic_enable,
    output logic                           outputs_enable,
    output logic                           low_power_request,
    output logic                           device_reset,
    output logic                           fn_conflict,
    output logic [PGSC_CFG_SEL_W-1:0]      cfg_index,
    output logic [PGSC_CFG_W-1:0]          cfg_active
);
    logic        pin_s;
    pgsc_state_t state_q, state_d;
    logic [PGSC_LOAD_CNT_W-1:0] cnt_q, cnt_d;
    logic        loaded_q, loaded_d;
    logic [PGSC_CFG_W-1:0]     cfg_q, cfg_d;
    logic [PGSC_CFG_SEL_W-1:0] idx_q, idx_d;
    logic        load_q, load_d;
    logic        ext_ok;
    logic        fn_sleep;
    logic        fn_reboot;
    logic        fn_none;

    // Start-up release: the pin when a pin function is set, otherwise the last supply alone
    function automatic logic start_ok(input logic none, input logic pin, input logic supply);
        return none ? supply : pin;
    endfunction

    pgsc_sync #(.STAGES(PGSC_SYNC_STAGES)) u_sync ( // [R14]
        .mclk (mclk),
        .rst  (rst),
        .din  (power_good_pin),
        .dout (pin_s)
    );

    // An illegal code with both variants is treated as no pin function
    assign fn_sleep  = (pin_function == PGSC_FN_SLEEP);  // [R11]
    assign fn_reboot = (pin_function == PGSC_FN_REBOOT); // [R11]
    assign fn_none   = !fn_sleep && !fn_reboot;
    assign ext_ok    = (FACTORY_CODE == PGSC_EXT_FETCH_CODE); // [R13]

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        loaded_d = loaded_q;
        cfg_d    = cfg_q;
        idx_d    = idx_q;
        load_d   = 1'b0;
        case (state_q)
            PGSC_ST_HOLD: begin
                // Pin function absent: supply validity alone releases start-up
                if (start_ok(fn_none, pin_s, supplies_valid_level)) begin // [R1] [R12]
                    state_d = PGSC_ST_LOAD;
                    cnt_d   = '0;
                    idx_d   = cfg_select; // [R5] [R10]
                end
            end
            PGSC_ST_LOAD: begin
                // Supply loss also aborts a pin-free start-up, so outputs never open early
                if (!start_ok(fn_none, pin_s, supplies_valid_level)) begin
                    state_d = PGSC_ST_HOLD; // [R1] [R12]
                end else if (cnt_q >= LOAD_CYC[PGSC_LOAD_CNT_W-1:0] - 1'b1) begin
                    state_d  = PGSC_ST_RUN;
                    loaded_d = 1'b1;
                    load_d   = 1'b1;
                    cfg_d    = ext_ok ? cfg_ext_data : cfg_store_data; // [R5] [R13]
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PGSC_ST_RUN: begin
                if (fn_sleep && !pin_s) begin
                    state_d = PGSC_ST_SLEEP; // [R7]
                end else if (fn_reboot && !pin_s) begin
                    state_d  = PGSC_ST_HOLD; // [R9]
                    loaded_d = 1'b0;
                end else if (fn_none && !supplies_valid_level) begin
                    state_d = PGSC_ST_HOLD; // [R12]
                end
            end
            PGSC_ST_SLEEP: begin
                // Configuration registers keep their contents while asleep
                if (pin_s) begin
                    state_d = PGSC_ST_WAKE; // [R6] [R8]
                end
            end
            PGSC_ST_WAKE: begin
                state_d = pin_s ? PGSC_ST_RUN : PGSC_ST_SLEEP; // [R8]
            end
            default: begin
                state_d  = PGSC_ST_HOLD;
                loaded_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q  <= PGSC_ST_HOLD;
            cnt_q    <= '0;
            loaded_q <= 1'b0;
            cfg_q    <= PGSC_CFG_RST;
            idx_q    <= '0;
            load_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            loaded_q <= loaded_d;
            cfg_q    <= cfg_d;
            idx_q    <= idx_d;
            load_q   <= load_d;
        end
    end

    assign startup_busy      = (state_q == PGSC_ST_HOLD) || (state_q == PGSC_ST_LOAD);
    assign cfg_load_pulse    = load_q;
    assign ext_fetch_en      = ext_ok && (state_q == PGSC_ST_LOAD); // [R13]
    assign synth_enable      = (state_q == PGSC_ST_RUN) || (state_q == PGSC_ST_WAKE); // [R7]
    assign logic_enable      = (state_q != PGSC_ST_SLEEP); // [R7]
    assign outputs_enable    = (state_q == PGSC_ST_RUN); // [R12]
    assign low_power_request = (state_q == PGSC_ST_SLEEP); // [R7]
    assign device_reset      = fn_reboot && (state_q == PGSC_ST_HOLD); // [R9]
    assign fn_conflict       = (pin_function == PGSC_FN_INVALID); // [R11]
    assign cfg_index         = idx_q;
    assign cfg_active        = cfg_q;

    chk_hold_no_out: assert property (@(posedge mclk) disable iff (rst)
        (!fn_none && !pin_s) |=> !outputs_enable || $past(state_q) == PGSC_ST_RUN) // [R1]
        else $error("outputs enabled while pin low");
    chk_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
        (state_q == PGSC_ST_RUN && fn_sleep && !pin_s) |=> low_power_request) // [R7]
        else $error("sleep not entered");
    chk_sleep_synth: assert property (@(posedge mclk) disable iff (rst)
        low_power_request |-> !synth_enable && !outputs_enable) // [R7]
        else $error("synthesizer on in low power");
    chk_wake_keep: assert property (@(posedge mclk) disable iff (rst)
        (state_q == PGSC_ST_SLEEP && pin_s) |=> ##1 (cfg_q == $past(cfg_q, 2)) && !load_q) // [R6] [R8]
        else $error("configuration changed on wake");
    chk_reboot_rst: assert property (@(posedge mclk) disable iff (rst)
        (state_q == PGSC_ST_RUN && fn_reboot && !pin_s) |=> device_reset && !loaded_q) // [R9]
        else $error("restart not taken");
    chk_load_time: assert property (@(posedge mclk) disable iff (rst)
        ($rose(state_q == PGSC_ST_LOAD) && pin_s && !fn_none) ##1 pin_s [*1]
        |-> ##[0:20] (cfg_load_pulse || state_q == PGSC_ST_HOLD)) // [R5] [R10]
        else $error("configuration load late");
    chk_none_gate: assert property (@(posedge mclk) disable iff (rst)
        (fn_none && outputs_enable) |-> $past(supplies_valid_level)) // [R12]
        else $error("outputs ungated without valid supply");
    chk_ext_fetch: assert property (@(posedge mclk) disable iff (rst)
        ext_fetch_en |-> (FACTORY_CODE == PGSC_EXT_FETCH_CODE)) // [R13]
        else $error("external fetch without code");
    chk_both_fn: assert property (@(posedge mclk) disable iff (rst)
        fn_conflict |-> !device_reset && !low_power_request) // [R11]
        else $error("both pin variants active");

    // Start-up release, load path, sleep and wake, restart and synchroniser
    chk_reset_idle: assert property (@(posedge mclk) // [R1]
        rst |=> state_q == PGSC_ST_HOLD && !outputs_enable)
        else $error("state not idle after reset");
    chk_load_abort: assert property (@(posedge mclk) disable iff (rst) // [R1]
        (state_q == PGSC_ST_LOAD && !start_ok(fn_none, pin_s, supplies_valid_level))
        |=> state_q == PGSC_ST_HOLD && !load_q)
        else $error("load not aborted");
    chk_load_src: assert property (@(posedge mclk) disable iff (rst) // [R5] [R13]
        load_q |-> cfg_q == (ext_ok ? $past(cfg_ext_data) : $past(cfg_store_data)))
        else $error("configuration from wrong source");
    chk_sel_capture: assert property (@(posedge mclk) disable iff (rst) // [R5] [R10]
        (state_q == PGSC_ST_HOLD && start_ok(fn_none, pin_s, supplies_valid_level))
        |=> cfg_index == $past(cfg_select))
        else $error("selection not captured");
    chk_wake_run: assert property (@(posedge mclk) disable iff (rst) // [R8]
        (state_q == PGSC_ST_WAKE && pin_s) |=> outputs_enable && !load_q)
        else $error("wake did not resume");
    chk_sleep_logic: assert property (@(posedge mclk) disable iff (rst) // [R7]
        low_power_request |-> !logic_enable)
        else $error("logic on in low power");
    chk_reboot_load: assert property (@(posedge mclk) disable iff (rst) // [R10]
        (state_q == PGSC_ST_HOLD && fn_reboot && pin_s) |=> state_q == PGSC_ST_LOAD)
        else $error("no reload after restart");
    chk_gate_busy: assert property (@(posedge mclk) disable iff (rst) // [R12]
        startup_busy |-> !outputs_enable)
        else $error("outputs open during start-up");
    chk_sync_delay: assert property (@(posedge mclk) disable iff (rst) // [R14]
        (!$past(rst) && !$past(rst, 2)) |-> pin_s == $past(power_good_pin, 2))
        else $error("pin not delayed by synchroniser");
    chk_load_count: assert property (@(posedge mclk) disable iff (rst) // [R5]
        cfg_load_pulse |-> $past(state_q == PGSC_ST_LOAD))
        else $error("load pulse outside load");
    chk_reset_out: assert property (@(posedge mclk) disable iff (rst) // [R9]
        device_reset |-> fn_reboot && startup_busy)
        else $error("device reset outside restart hold");
endmodule

// file: bench/pgsc_supervisor.sv
`timescale 1ns/100ps
module pgsc_supervisor #(
    parameter int HOLD_CYC = 4
) (
    input  wire logic mclk,
    input  wire logic rails_on,
    input  wire logic pg_req,
    output logic      supplies_valid_level,
    output logic      power_good_pin
);
    logic [7:0] hold_q;
    initial begin
        supplies_valid_level = 1'b0;
        power_good_pin = 1'b0;
        hold_q = 8'h00;
    end
    always @(posedge mclk) begin
        supplies_valid_level <= rails_on;
        // Hold count restarts whenever the last rail drops
        if (!supplies_valid_level) begin
            hold_q <= 8'h00;
        end else if (hold_q < 8'(HOLD_CYC)) begin
            hold_q <= hold_q + 8'h01;
        end
        // Low from power-up; high only with rails valid and hold time over
        power_good_pin <= pg_req && supplies_valid_level && (hold_q >= 8'(HOLD_CYC));
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
    import pgsc_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, rails_on = 1'b0, pg_req = 1'b0, watch_on = 1'b0;
    logic [1:0] pin_function = 2'b00, sel = 2'b00;
    logic [7:0] store_d = 8'h00, ext_d = 8'h00, d1, d2;
    logic [15:0] seed = 16'hf133;
    logic pin, supply, busy, pulse, fetch, synth, lgc, oen, lpr, dres, conflict;
    logic [1:0] idx;
    logic [7:0] active;
    logic [7:0] exp_q[$];
    int bad_count = 0, cmp_count = 0;
    always #50 mclk = ~mclk;
    pgsc_supervisor pgsc_supervisor_i (.mclk(mclk), .rails_on(rails_on), .pg_req(pg_req),
        .supplies_valid_level(supply), .power_good_pin(pin));
    pgsc_top #(.LOAD_CYC(2), .FACTORY_CODE(8'h5a)) pgsc_top_i (.mclk(mclk), .rst(rst),
        .power_good_pin(pin), .pin_function(pin_function), .supplies_valid_level(supply),
        .cfg_select(sel), .cfg_store_data(store_d), .cfg_ext_data(ext_d),
        .startup_busy(busy), .cfg_load_pulse(pulse), .ext_fetch_en(fetch),
        .synth_enable(synth), .logic_enable(lgc), .outputs_enable(oen),
        .low_power_request(lpr), .device_reset(dres), .fn_conflict(conflict),
        .cfg_index(idx), .cfg_active(active));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Each load pulse while watch_on is set must match the oldest expected configuration; a surplus pulse is an error
    always @(posedge mclk) begin
        if (watch_on && pulse === 1'b1) begin
            if (exp_q.size() == 0) check(8'h01, 8'h00);
            else check(active, exp_q.pop_front());
        end
    end
    function automatic logic sig(input int k);
        case (k)
            0: return oen;
            1: return lpr;
            default: return dres;
        endcase
    endfunction
    task automatic wait_sig(input int k, input logic v);
        for (int i = 0; i < 200 && sig(k) !== v; i++) @(posedge mclk) #1;
        if (sig(k) !== v) begin
            bad_count++;
            $display("mismatch at %0t: wait on output %0d ran out", $time, k);
            stop_test();
        end
    endtask
    task automatic reset_dut(input logic [1:0] fn);
        @(posedge mclk) #1;
        rst = 1'b1;
        pin_function = fn;
        pg_req = 1'b0;
        rails_on = 1'b0;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        check(8'(conflict), 8'(fn == 2'b11));
        check(8'(oen), 8'h00);
    endtask
    // Rails on, new random configuration, then pin released; the load is expected on the queue
    task automatic power_up(output logic [7:0] d);
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        d = seed[7:0];
        ext_d = d;
        store_d = ~d;
        sel = seed[9:8];
        rails_on = 1'b1;
        repeat (12) @(posedge mclk) #1;
        check(8'(busy), 8'h01);
        check(8'(oen), 8'h00);
        exp_q.push_back(d);
        pg_req = 1'b1;
        repeat (4) @(posedge mclk) #1;
        check(8'(fetch), 8'h01);
        wait_sig(0, 1'b1);
        repeat (3) @(posedge mclk) #1;
        check(8'(idx), 8'(sel));
    endtask
    initial begin
        reset_dut(2'b01);
        watch_on = 1'b1;
        power_up(d1);
        pg_req = 1'b0;
        wait_sig(1, 1'b1);
        check({6'h00, synth, lgc}, 8'h00);
        ext_d = ~d1;
        sel = ~sel;
        pg_req = 1'b1;
        wait_sig(0, 1'b1);
        repeat (4) @(posedge mclk) #1;
        check(active, d1);
        check({6'h00, synth, lgc}, 8'h03);
        $display("test sleep variant done");
        reset_dut(2'b10);
        power_up(d1);
        pg_req = 1'b0;
        wait_sig(2, 1'b1);
        check(8'(oen), 8'h00);
        power_up(d2);
        $display("test reboot variant done");
        watch_on = 1'b0;
        reset_dut(2'b00);
        pg_req = 1'b1;
        repeat (8) @(posedge mclk) #1;
        check(8'(oen), 8'h00);
        rails_on = 1'b1;
        wait_sig(0, 1'b1);
        reset_dut(2'b11);
        $display("test no function done");
        check(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
